// [logic/gei_defs.svh]
// Offsets, field layout, reset values and timing counts of the edge request status block.
// Assumes a byte address of eight bits on the plain register port.
`ifndef GEI_DEFS_SVH
`define GEI_DEFS_SVH

// Register offsets
`define GEI_STATUS_OFS  8'h00
`define GEI_TYPE_OFS    8'h04
`define GEI_ENABLE_OFS  8'h08
`define GEI_CLEAR_OFS   8'h0C

// Field layout
`define GEI_TYPE_BITS   2
`define GEI_MAX_LINES   8

// Reset values
`define GEI_TYPE_RST    16'h0000
`define GEI_ENABLE_RST  8'h00

// Input samples needed before edges are trusted
`define GEI_PRIME_CYC   2'h3

`endif

// [logic/gei_pkg.sv]
// Shared types of the edge request status block.
// Assumes nothing beyond a SystemVerilog compiler.
package gei_pkg;

	// Trigger condition of one line, in the order of its two-bit code
	typedef enum logic [1:0] {
		GEI_LOW,
		GEI_HIGH,
		GEI_FALL,
		GEI_RISE
	} gei_trig_t;

endpackage

// [logic/gei_edge_if.sv]
// Edge and level events passed from the input sampler to the flag logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps

interface gei_edge_if #(
	parameter int LINES = 8
);
	logic [LINES-1:0] rise;
	logic [LINES-1:0] fall;
	logic [LINES-1:0] lvl;

	modport det (output rise, output fall, output lvl);
	modport top (input rise, input fall, input lvl);
endinterface

// [logic/gei_edge_det.sv]
// Input synchroniser and edge detector for the general-purpose input lines.
// Assumes the inputs are asynchronous pins and clk_i is the system clock.
`timescale 1ns/10ps
`include "gei_defs.svh"

module gei_edge_det #(
	parameter int LINES = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Pins and events
	input  wire logic [LINES-1:0] pin_i,
	gei_edge_if.det               ev
);
	typedef struct packed {
		logic [LINES-1:0] s1;
		logic [LINES-1:0] s2;
		logic [LINES-1:0] prev;
		logic [1:0]       prime;
	} gei_det_st_t;

	gei_det_st_t st;
	gei_det_st_t next_st;
	logic        primed;

	// Shift samples; count until the previous sample holds real pin data
	always_comb begin
		next_st       = st;
		next_st.s1    = pin_i;
		next_st.s2    = st.s1;
		next_st.prev  = st.s2;
		if (st.prime != `GEI_PRIME_CYC) begin
			next_st.prime = st.prime + 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Compare each synced sample with the one before it
	assign primed  = (st.prime == `GEI_PRIME_CYC);
	assign ev.rise = primed ? (st.s2 & ~st.prev) : '0;
	assign ev.fall = primed ? (~st.s2 & st.prev) : '0;
	assign ev.lvl  = st.s2;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	edge_rise_a: assert property ((ev.rise & ~($past(pin_i, 2) & ~$past(pin_i, 3))) == '0)
		else $error("rise reported without a low to high pin change");
	edge_fall_a: assert property ((ev.fall & ~(~$past(pin_i, 2) & $past(pin_i, 3))) == '0)
		else $error("fall reported without a high to low pin change");
endmodule

// [logic/gei_top.sv]
// Edge request status block: sticky per-line flags, request lines and register port.
// Assumes a plain register master on clk_i and asynchronous input pins.
// What this block does
// - Eight flags, bits 7..0, one per line
// - Configured edge seen sets that line's flag
// - Flag stays zero without a configured edge
// - Writing one clears exactly those flags, except a flag that a new edge sets in the same cycle
// - Flag and edge line's request hold until cleared; level line requests follow the pin
// - Type codes: low, high, falling, rising
`timescale 1ns/10ps
`include "gei_defs.svh"

module gei_top #(
	parameter int LINES = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Input pins
	input  wire logic [LINES-1:0] gpio_in_i,
	// Register port
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [31:0]      reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [31:0]      reg_rdata_o,
	// Interrupt requests
	output logic      [LINES-1:0] gpio_irq_o,
	output logic                  irq_o
);
	if (LINES < 1 || LINES > `GEI_MAX_LINES) begin : g_bad_lines
		$error("LINES must lie between 1 and 8");
	end

	typedef struct packed {
		logic [LINES-1:0]                 flag;
		logic [`GEI_TYPE_BITS*LINES-1:0] trig;
		logic [LINES-1:0]                 en;
		logic [LINES-1:0]                 req;
		logic                             irq;
		logic [31:0]                      rdata;
	} gei_top_st_t;

	gei_top_st_t      st;
	gei_top_st_t      next_st;
	logic [LINES-1:0] edge_hit;
	logic [LINES-1:0] lvl_hit;
	logic [LINES-1:0] clr_v;
	logic [LINES-1:0] is_edge;

	gei_edge_if #(.LINES(LINES)) ev ();

	// Sampler and edge detector
	gei_edge_det #(.LINES(LINES)) u_det (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   (gpio_in_i),
		.ev      (ev)
	);

	// Decode trigger type of one line from the packed type field
	function automatic gei_pkg::gei_trig_t trig_of(input logic [`GEI_TYPE_BITS*LINES-1:0] t, input int n);
		trig_of = gei_pkg::gei_trig_t'(t[n*`GEI_TYPE_BITS +: `GEI_TYPE_BITS]);
	endfunction

	// Per-line event match and write-one clear mask
	always_comb begin
		edge_hit = '0;
		lvl_hit  = '0;
		is_edge  = '0;
		for (int i = 0; i < LINES; i++) begin
			case (trig_of(st.trig, i))
				gei_pkg::GEI_LOW: begin
					lvl_hit[i] = ~ev.lvl[i];
				end
				gei_pkg::GEI_HIGH: begin
					lvl_hit[i] = ev.lvl[i];
				end
				gei_pkg::GEI_FALL: begin
					is_edge[i]  = 1'b1;
					edge_hit[i] = ev.fall[i];
				end
				gei_pkg::GEI_RISE: begin
					is_edge[i]  = 1'b1;
					edge_hit[i] = ev.rise[i];
				end
				default: begin
					lvl_hit[i] = 1'b0;
				end
			endcase
		end
		// Only ones in the low bits clear; zeros and upper bits do nothing
		if (reg_wr_i && (reg_addr_i == `GEI_STATUS_OFS || reg_addr_i == `GEI_CLEAR_OFS)) begin
			clr_v = reg_wdata_i[LINES-1:0];
		end else begin
			clr_v = '0;
		end
	end

	// Next state: flags, configuration, requests and read data
	always_comb begin
		next_st = st;
		// A new edge beats a clear in the same cycle
		next_st.flag = (st.flag & ~clr_v) | edge_hit;
		if (reg_wr_i && reg_addr_i == `GEI_TYPE_OFS) begin
			next_st.trig = reg_wdata_i[`GEI_TYPE_BITS*LINES-1:0];
		end
		if (reg_wr_i && reg_addr_i == `GEI_ENABLE_OFS) begin
			next_st.en = reg_wdata_i[LINES-1:0];
		end
		// Edge lines hold on the flag, level lines follow the pin
		next_st.req = next_st.flag | lvl_hit;
		next_st.irq = |(next_st.flag & next_st.en);
		next_st.rdata = '0;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`GEI_STATUS_OFS: begin
					next_st.rdata = 32'(st.flag);
				end
				`GEI_TYPE_OFS: begin
					next_st.rdata = 32'(st.trig);
				end
				`GEI_ENABLE_OFS: begin
					next_st.rdata = 32'(st.en);
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st       <= '0;
			st.trig  <= (`GEI_TYPE_BITS*LINES)'(`GEI_TYPE_RST);
			st.en    <= LINES'(`GEI_ENABLE_RST);
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign gpio_irq_o  = st.req;
	assign irq_o       = st.irq;
	assign reg_rdata_o = st.rdata;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	flag_set_a: assert property (|edge_hit |=> (st.flag & $past(edge_hit)) == $past(edge_hit))
		else $error("detected edge did not set its flag");
	no_level_set_a: assert property (1'b1 |=> (st.flag & ~$past(st.flag) & ~$past(edge_hit)) == '0)
		else $error("flag set without a configured edge");
	clr_exact_a: assert property (|clr_v |=> (st.flag & $past(clr_v & ~edge_hit)) == '0
		&& (st.flag & $past(st.flag & ~clr_v)) == $past(st.flag & ~clr_v))
		else $error("write one clear did not act on exactly the written flags");
	flag_hold_a: assert property (1'b1 |=> ($past(st.flag & ~clr_v) & ~gpio_irq_o) == '0)
		else $error("set flag or its request dropped without a clear");
	type_sel_a: assert property ((edge_hit & ~is_edge) == '0 && (lvl_hit & is_edge) == '0)
		else $error("request condition does not match the line type");
	irq_line_a: assert property (1'b1 |=> gpio_irq_o == $past((st.flag & ~clr_v) | edge_hit | lvl_hit))
		else $error("request line does not follow its flag");
	upper_zero_a: assert property (reg_rd_i && reg_addr_i == `GEI_STATUS_OFS
		|=> reg_rdata_o == 32'($past(st.flag)))
		else $error("status read shows wrong flags or nonzero upper bits");
	irq_out_a: assert property (irq_o == |(st.flag & st.en))
		else $error("interrupt output does not match enabled flags");

	flag_set_c: cover property (|edge_hit ##1 |st.flag);
	set_wins_c: cover property (|(edge_hit & clr_v));
	irq_rise_c: cover property (!irq_o ##1 irq_o);
	status_rd_c: cover property (reg_rd_i && reg_addr_i == `GEI_STATUS_OFS && |st.flag);
endmodule

// [tb/gei_irq_sink.sv]
// Far-side interrupt sink: counts each new combined request.
// Assumes the same clock and reset as the block.
`timescale 1ns/10ps

module gei_irq_sink (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Requests
	input  wire logic       irq_i,
	output logic      [7:0] rise_cnt_o
);
	logic irq_q;

	// Counts rising edges of the combined level request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q      <= 1'b0;
			rise_cnt_o <= 8'h00;
		end else begin
			irq_q <= irq_i;
			if (irq_i && !irq_q) begin
				rise_cnt_o <= rise_cnt_o + 8'h01;
			end
		end
	end
endmodule

// [tb/testbench.sv]
// Self-checking bench of the edge request status block.
// Assumes the block's register port and the interrupt sink model.
`timescale 1ns/10ps
`include "gei_defs.svh"

module testbench;
	logic        clk_i       = 1'b0;
	logic        rst_n_i     = 1'b0;
	logic [7:0]  gpio_in_i   = 8'hFF;
	logic [7:0]  reg_addr_i  = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [7:0]  gpio_irq_o;
	logic        irq_o;
	logic [7:0]  rise_cnt;
	int          err_count   = 0;
	int          n_compared  = 0;
	int          cyc         = 0;

	// Clock of 50 ns period
	always #25 clk_i = ~clk_i;

	gei_top #(.LINES(8)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .gpio_in_i(gpio_in_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .gpio_irq_o(gpio_irq_o), .irq_o(irq_o));

	gei_irq_sink sink_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_i(irq_o), .rise_cnt_o(rise_cnt));

	// Compares and counts
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// One-cycle read strobe; data checked mid-cycle after it, while it stands
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		chk(reg_rdata_o, exp);
		@(posedge clk_i);
	endtask

	// New pin levels, then time for sync and flag stages
	task automatic pins(input logic [7:0] v);
		gpio_in_i <= v;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			end_of_test();
		end
	end

	// Test sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(`GEI_STATUS_OFS, 32'h0);
		rd(`GEI_TYPE_OFS, 32'h0);
		rd(`GEI_CLEAR_OFS, 32'h0);
		rd(8'h10, 32'h0);
		$display("test reset done");
		// Lines 0..7 take codes low, high, fall, rise, twice over
		wr(`GEI_TYPE_OFS, 32'h0000E4E4);
		rd(`GEI_TYPE_OFS, 32'h0000E4E4);
		pins(8'h00);
		rd(`GEI_STATUS_OFS, 32'h44);
		chk(gpio_irq_o, 32'h55);
		pins(8'hFF);
		rd(`GEI_STATUS_OFS, 32'hCC);
		chk(gpio_irq_o, 32'hEE);
		chk(irq_o, 32'h0);
		$display("test edges done");
		wr(`GEI_ENABLE_OFS, 32'h4);
		rd(`GEI_ENABLE_OFS, 32'h4);
		chk(irq_o, 32'h1);
		repeat (20) @(posedge clk_i);
		wr(`GEI_STATUS_OFS, 32'hFFFFFF00);
		rd(`GEI_STATUS_OFS, 32'hCC);
		wr(`GEI_STATUS_OFS, 32'h04);
		rd(`GEI_STATUS_OFS, 32'hC8);
		chk(irq_o, 32'h0);
		wr(`GEI_CLEAR_OFS, 32'h80);
		rd(`GEI_STATUS_OFS, 32'h48);
		chk(gpio_irq_o, 32'h6A);
		chk(rise_cnt, 32'h1);
		wr(`GEI_STATUS_OFS, 32'hFFFFFFFF);
		rd(`GEI_STATUS_OFS, 32'h0);
		$display("test clear done");
		// Second reset with flags pending
		pins(8'h00);
		rst_n_i <= 1'b0;
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(`GEI_STATUS_OFS, 32'h0);
		rd(`GEI_TYPE_OFS, 32'h0);
		chk(gpio_irq_o, 32'hFF);
		$display("test second reset done");
		end_of_test();
	end
endmodule
